// File: design/mdp_pkg.sv
package mdp_pkg;
	localparam int DELTA_W = 8;
	localparam int REG_W = 8;
	localparam int ADDR_W = 8;
	localparam int SHUTTER_W = 16;
	localparam int SHIFT_W = 3;
	localparam int OFFSET_W = 2;
	localparam int THRESH_W = 6;

	localparam logic [ADDR_W-1:0] QUANT_ADDR = 8'h73;
	localparam logic [ADDR_W-1:0] SLOPE_ADDR = 8'h74;
	localparam logic [ADDR_W-1:0] PRES_ADDR = 8'h75;
	localparam logic [ADDR_W-1:0] RSVD_ADDR = 8'h76;
	localparam logic [ADDR_W-1:0] ORIENT_ADDR = 8'h77;

	localparam logic [REG_W-1:0] QUANT_RST = 8'h00;
	localparam logic [REG_W-1:0] SLOPE_RST = 8'h02;
	localparam logic [REG_W-1:0] PRES_RST = 8'h50;
	localparam logic [REG_W-1:0] ORIENT_RST = 8'h00;
	localparam logic [REG_W-1:0] RSVD_READ = 8'h00;

	localparam int V_EN_BIT = 7;
	localparam int V_SHIFT_LSB = 4;
	localparam int H_EN_BIT = 3;
	localparam int H_SHIFT_LSB = 0;
	localparam int SLOPE_BIT = 2;
	localparam int OFFSET_LSB = 0;
	localparam int POL_BIT = 6;
	localparam int THRESH_LSB = 0;
	localparam int EXCH_BIT = 7;
	localparam int VNEG_BIT = 6;
	localparam int HNEG_BIT = 5;
	localparam int ANGLE_LSB = 0;

	localparam logic [REG_W-1:0] SLOPE_WMASK = 8'h07;
	localparam logic [REG_W-1:0] PRES_WMASK = 8'h7F;
	localparam logic [REG_W-1:0] ORIENT_WMASK = 8'hE0;

	localparam int SHUTTER_SHIFT = 5;
	localparam logic [DELTA_W-1:0] DELTA_MAX = 8'h7F;
	localparam int AXIS_H = 0;
	localparam int AXIS_V = 1;
endpackage : mdp_pkg

// File: design/mdp_axis_quant.sv
`timescale 1ns/1ps
module mdp_axis_quant
	import mdp_pkg::*;
(
	input wire logic signed [DELTA_W-1:0] delta_in,
	input wire logic step_enable,
	input wire logic [SHIFT_W-1:0] step_shift,
	input wire logic slope_select,
	input wire logic [OFFSET_W-1:0] linear_offset,
	output logic signed [DELTA_W-1:0] delta_out,
	output logic [DELTA_W:0] magnitude
);
	logic [DELTA_W:0] abs_val;
	logic [DELTA_W:0] stepped;
	logic [DELTA_W+1:0] curve;
	logic [DELTA_W-1:0] sat;

	// Magnitude is divided, mapped through the linear region, saturated, then re-signed.
	always_comb begin
		abs_val = delta_in[DELTA_W-1] ? (DELTA_W+1)'(-$signed({delta_in[DELTA_W-1], delta_in}))
			: {1'b0, delta_in};
		stepped = abs_val >> step_shift;
		if (stepped == '0) begin
			curve = '0;
		end else begin
			curve = (slope_select ? {stepped, 1'b0} : {1'b0, stepped})
				+ (DELTA_W+2)'(linear_offset);
		end
		sat = (curve > (DELTA_W+2)'(DELTA_MAX)) ? DELTA_MAX : curve[DELTA_W-1:0];
		if (step_enable) begin
			delta_out = delta_in[DELTA_W-1] ? -$signed(sat) : $signed(sat);
			magnitude = {1'b0, sat};
		end else begin
			delta_out = delta_in;
			magnitude = abs_val;
		end
	end
endmodule : mdp_axis_quant

// File: design/mdp_presence.sv
`timescale 1ns/1ps
module mdp_presence
	import mdp_pkg::*;
(
	input wire logic [SHUTTER_W-1:0] shutter,
	input wire logic [THRESH_W-1:0] presence_threshold,
	input wire logic presence_polarity,
	output logic pin_level
);
	logic [SHUTTER_W-1:0] scaled;
	logic present;

	always_comb begin
		scaled = shutter >> SHUTTER_SHIFT;
		present = scaled <= SHUTTER_W'(presence_threshold);
		pin_level = presence_polarity ? present : ~present;
	end
endmodule : mdp_presence

// File: design/mdp_top.sv
`timescale 1ns/1ps
module mdp_top
	import mdp_pkg::*;
(
	clk,
	rst,
	reg_addr,
	reg_wr,
	reg_rd,
	reg_wdata,
	reg_rdata,
	reg_rvalid,
	raw_valid,
	raw_horizontal_delta,
	raw_vertical_delta,
	shutter,
	orient_pin,
	rpt_valid,
	horizontal_delta,
	vertical_delta,
	finger_presence_detect
);
	input wire logic clk;
	input wire logic rst;
	input wire logic [ADDR_W-1:0] reg_addr;
	input wire logic reg_wr;
	input wire logic reg_rd;
	input wire logic [REG_W-1:0] reg_wdata;
	output logic [REG_W-1:0] reg_rdata;
	output logic reg_rvalid;
	input wire logic raw_valid;
	input wire logic signed [DELTA_W-1:0] raw_horizontal_delta;
	input wire logic signed [DELTA_W-1:0] raw_vertical_delta;
	input wire logic [SHUTTER_W-1:0] shutter;
	input wire logic orient_pin;
	output logic rpt_valid;
	output logic signed [DELTA_W-1:0] horizontal_delta;
	output logic signed [DELTA_W-1:0] vertical_delta;
	output logic finger_presence_detect;

	// Control registers.
	logic [REG_W-1:0] quant_r, quant_nxt;
	logic [REG_W-1:0] slope_r, slope_nxt;
	logic [REG_W-1:0] pres_r, pres_nxt;
	logic [REG_W-1:0] orient_r, orient_nxt;
	logic [REG_W-1:0] rdata_r, rdata_nxt;
	logic rvalid_r, rvalid_nxt;

	// Orientation pin synchroniser.
	logic orient_s1_r, orient_s2_r;

	// Motion report and presence output.
	logic rpt_valid_r, rpt_valid_nxt;
	logic signed [DELTA_W-1:0] hd_r, hd_nxt;
	logic signed [DELTA_W-1:0] vd_r, vd_nxt;
	logic fpd_r, fpd_nxt;

	logic axis_exchange, vertical_negate, horizontal_negate;
	logic vertical_step_enable, horizontal_step_enable;
	logic [SHIFT_W-1:0] vertical_step_shift, horizontal_step_shift;
	logic slope_select;
	logic [OFFSET_W-1:0] linear_offset;
	logic presence_polarity;
	logic [THRESH_W-1:0] presence_threshold;
	logic [1:0] mount_angle_state;

	logic signed [DELTA_W-1:0] oriented [2];
	logic signed [DELTA_W-1:0] quantized [2];
	logic [DELTA_W:0] mag [2];
	logic axis_en [2];
	logic [SHIFT_W-1:0] axis_shift [2];
	logic presence_level;

	assign axis_exchange = orient_r[EXCH_BIT];
	assign vertical_negate = orient_r[VNEG_BIT];
	assign horizontal_negate = orient_r[HNEG_BIT];
	assign vertical_step_enable = quant_r[V_EN_BIT];
	assign horizontal_step_enable = quant_r[H_EN_BIT];
	assign vertical_step_shift = quant_r[V_SHIFT_LSB +: SHIFT_W];
	assign horizontal_step_shift = quant_r[H_SHIFT_LSB +: SHIFT_W];
	assign slope_select = slope_r[SLOPE_BIT];
	assign linear_offset = slope_r[OFFSET_LSB +: OFFSET_W];
	assign presence_polarity = pres_r[POL_BIT];
	assign presence_threshold = pres_r[THRESH_LSB +: THRESH_W];
	// Pin high reads 0x01, pin low reads 0x00.
	assign mount_angle_state = {1'b0, orient_s2_r};

	// Exchange first, then per-axis negation, ahead of quantization.
	always_comb begin
		if (axis_exchange) begin
			oriented[AXIS_H] = raw_vertical_delta;
			oriented[AXIS_V] = raw_horizontal_delta;
		end else begin
			oriented[AXIS_H] = raw_horizontal_delta;
			oriented[AXIS_V] = raw_vertical_delta;
		end
		if (horizontal_negate) begin
			oriented[AXIS_H] = -oriented[AXIS_H];
		end
		if (vertical_negate) begin
			oriented[AXIS_V] = -oriented[AXIS_V];
		end
	end

	assign axis_en[AXIS_H] = horizontal_step_enable;
	assign axis_en[AXIS_V] = vertical_step_enable;
	assign axis_shift[AXIS_H] = horizontal_step_shift;
	assign axis_shift[AXIS_V] = vertical_step_shift;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_axis
			mdp_axis_quant u_quant (
				.delta_in(oriented[g]),
				.step_enable(axis_en[g]),
				.step_shift(axis_shift[g]),
				.slope_select(slope_select),
				.linear_offset(linear_offset),
				.delta_out(quantized[g]),
				.magnitude(mag[g])
			);
		end
	endgenerate

	mdp_presence u_presence (
		.shutter(shutter),
		.presence_threshold(presence_threshold),
		.presence_polarity(presence_polarity),
		.pin_level(presence_level)
	);

	// Report path: one registered result per raw sample.
	always_comb begin
		rpt_valid_nxt = raw_valid;
		hd_nxt = hd_r;
		vd_nxt = vd_r;
		if (raw_valid) begin
			hd_nxt = quantized[AXIS_H];
			vd_nxt = quantized[AXIS_V];
			if (horizontal_step_enable && vertical_step_enable) begin
				// Ties keep the horizontal axis.
				if (mag[AXIS_V] > mag[AXIS_H]) begin
					hd_nxt = '0;
				end else begin
					vd_nxt = '0;
				end
			end
		end
		fpd_nxt = presence_level;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			rpt_valid_r <= 1'b0;
			hd_r <= '0;
			vd_r <= '0;
			fpd_r <= 1'b0;
		end else begin
			rpt_valid_r <= rpt_valid_nxt;
			hd_r <= hd_nxt;
			vd_r <= vd_nxt;
			fpd_r <= fpd_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			orient_s1_r <= 1'b1;
			orient_s2_r <= 1'b1;
		end else begin
			orient_s1_r <= orient_pin;
			orient_s2_r <= orient_s1_r;
		end
	end

	// Register file: slope, presence and orientation writes store through a mask, quant stores whole; reads answer one cycle later.
	always_comb begin
		quant_nxt = quant_r;
		slope_nxt = slope_r;
		pres_nxt = pres_r;
		orient_nxt = orient_r;
		rvalid_nxt = reg_rd;
		rdata_nxt = rdata_r;
		if (reg_wr) begin
			case (reg_addr)
				QUANT_ADDR: begin
					quant_nxt = reg_wdata;
				end
				SLOPE_ADDR: begin
					slope_nxt = reg_wdata & SLOPE_WMASK;
				end
				PRES_ADDR: begin
					pres_nxt = reg_wdata & PRES_WMASK;
				end
				ORIENT_ADDR: begin
					orient_nxt = reg_wdata & ORIENT_WMASK;
				end
				default: begin
					quant_nxt = quant_r;
				end
			endcase
		end
		if (reg_rd) begin
			case (reg_addr)
				QUANT_ADDR: begin
					rdata_nxt = quant_r;
				end
				SLOPE_ADDR: begin
					rdata_nxt = slope_r;
				end
				PRES_ADDR: begin
					rdata_nxt = pres_r;
				end
				ORIENT_ADDR: begin
					rdata_nxt = orient_r | {6'h00, mount_angle_state};
				end
				default: begin
					rdata_nxt = RSVD_READ;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			quant_r <= QUANT_RST;
			slope_r <= SLOPE_RST;
			pres_r <= PRES_RST;
			orient_r <= ORIENT_RST;
			rdata_r <= '0;
			rvalid_r <= 1'b0;
		end else begin
			quant_r <= quant_nxt;
			slope_r <= slope_nxt;
			pres_r <= pres_nxt;
			orient_r <= orient_nxt;
			rdata_r <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	assign reg_rdata = rdata_r;
	assign reg_rvalid = rvalid_r;
	assign rpt_valid = rpt_valid_r;
	assign horizontal_delta = hd_r;
	assign vertical_delta = vd_r;
	assign finger_presence_detect = fpd_r;
endmodule : mdp_top

// File: test/mdp_top_monitor.sv
`timescale 1ns/1ps
module mdp_top_monitor
	import mdp_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_rvalid,
	input wire logic raw_valid,
	input wire logic signed [7:0] raw_horizontal_delta,
	input wire logic signed [7:0] raw_vertical_delta,
	input wire logic [15:0] shutter,
	input wire logic rpt_valid,
	input wire logic signed [7:0] horizontal_delta,
	input wire logic signed [7:0] vertical_delta,
	input wire logic finger_presence_detect
);
	logic [7:0] q_r, o_r, p_r;
	logic fpd_exp;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Shadow copies of the quant, orient and presence registers, updated as the host writes them.
	always_ff @(posedge clk) begin
		if (rst) begin
			q_r <= QUANT_RST;
			o_r <= ORIENT_RST;
			p_r <= PRES_RST;
		end else if (reg_wr) begin
			case (reg_addr)
				QUANT_ADDR: q_r <= reg_wdata;
				ORIENT_ADDR: o_r <= reg_wdata & ORIENT_WMASK;
				PRES_ADDR: p_r <= reg_wdata & PRES_WMASK;
				default: ;
			endcase
		end
	end
	assign fpd_exp = ((shutter >> SHUTTER_SHIFT) <= 16'(p_r[5:0])) == p_r[POL_BIT];
	sequence s_rd;
		reg_rd ##1 reg_rvalid;
	endsequence
	sequence s_mv;
		raw_valid ##1 rpt_valid;
	endsequence
	property p_rd_ans;
		reg_rd |-> s_rd;
	endproperty
	a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
	property p_rpt;
		raw_valid |-> s_mv;
	endproperty
	a_rpt: assert property (p_rpt) else $error("report late");
	property p_rpt_once;
		!raw_valid |=> !rpt_valid;
	endproperty
	a_rpt_once: assert property (p_rpt_once) else $error("report repeated");
	property p_rd_once;
		!reg_rd |=> !reg_rvalid;
	endproperty
	a_rd_once: assert property (p_rd_once) else $error("read answer repeated");
	property p_hold;
		!raw_valid |=> $stable(horizontal_delta) && $stable(vertical_delta);
	endproperty
	a_hold: assert property (p_hold) else $error("deltas moved");
	property p_pass;
		q_r == 8'h00 && o_r == 8'h00 && raw_valid |=> horizontal_delta ==
			$past(raw_horizontal_delta) && vertical_delta == $past(raw_vertical_delta);
	endproperty
	a_pass: assert property (p_pass) else $error("pass-through wrong");
	property p_swap;
		q_r == 8'h00 && o_r == 8'h80 && raw_valid |=> horizontal_delta ==
			$past(raw_vertical_delta) && vertical_delta == $past(raw_horizontal_delta);
	endproperty
	a_swap: assert property (p_swap) else $error("exchange wrong");
	property p_vneg;
		q_r == 8'h00 && o_r == 8'h40 && raw_valid |=> horizontal_delta ==
			$past(raw_horizontal_delta) && vertical_delta == -$past(raw_vertical_delta);
	endproperty
	a_vneg: assert property (p_vneg) else $error("vertical negate wrong");
	property p_both;
		q_r[7] && q_r[3] && raw_valid |=> horizontal_delta == 8'h00 || vertical_delta == 8'h00;
	endproperty
	a_both: assert property (p_both) else $error("both axes reported");
	property p_fpd;
		!$past(rst) |-> finger_presence_detect == $past(fpd_exp);
	endproperty
	a_fpd: assert property (p_fpd) else $error("presence wrong");
endmodule : mdp_top_monitor
bind mdp_top mdp_top_monitor u_mon (.*);

// File: test/mdp_host_model.sv
`timescale 1ns/1ps
module mdp_host_model
	import mdp_pkg::*;
(
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 8'h00;
		reg_wr = 1'h0;
		reg_rd = 1'h0;
		reg_wdata = 8'h00;
	end
	// Released address and data show their inverse so a stale value cannot pass.
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge clk);
		reg_wr <= 1'h0;
		reg_addr <= ~a;
		reg_wdata <= ~v;
	endtask : wr
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk);
		reg_rd <= 1'h0;
		reg_addr <= ~a;
		// Read data is registered at the taking edge and is captured at the next edge.
		@(posedge clk);
		v = reg_rdata;
	endtask : rd
	task set_fpd(input logic pol, input logic [15:0] shut);
		wr(PRES_ADDR, {1'h0, pol, shut[10:5]});
	endtask : set_fpd
endmodule : mdp_host_model

// File: test/mdp_top_tb.sv
`timescale 1ns/1ps
module mdp_top_tb
	import mdp_pkg::*;
;
	logic clk, rst, reg_wr, reg_rd, reg_rvalid, raw_valid, orient_pin, rpt_valid;
	logic finger_presence_detect;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
	logic signed [7:0] raw_horizontal_delta, raw_vertical_delta, horizontal_delta, vertical_delta;
	logic [15:0] shutter;
	int bad_count = 0;
	int comparisons = 0;
	// Rows: quant, slope, orient, raw h, raw v, expected h, expected v.
	logic [7:0] tbl [10][7] = '{
		'{8'h00, 8'h02, 8'h00, 8'h05, 8'hFD, 8'h05, 8'hFD},
		'{8'h00, 8'h02, 8'h80, 8'h05, 8'hFD, 8'hFD, 8'h05},
		'{8'h00, 8'h02, 8'h40, 8'h05, 8'hFD, 8'h05, 8'h03},
		'{8'h00, 8'h02, 8'h20, 8'h05, 8'hFD, 8'hFB, 8'hFD},
		'{8'hB0, 8'h00, 8'h00, 8'h05, 8'hD8, 8'h05, 8'hFB},
		'{8'h0A, 8'h07, 8'h00, 8'h14, 8'h07, 8'h0D, 8'h07},
		'{8'h0A, 8'h07, 8'h00, 8'h02, 8'h07, 8'h00, 8'h07},
		'{8'h99, 8'h00, 8'h00, 8'h0A, 8'hE2, 8'h00, 8'hF1},
		'{8'h08, 8'h07, 8'h00, 8'h64, 8'h01, 8'h7F, 8'h01},
		'{8'h88, 8'h02, 8'hA0, 8'h06, 8'hF7, 8'h0B, 8'h00}};
	logic [7:0] rst_exp [5] = '{8'h00, 8'h02, 8'h50, 8'h00, 8'h01};
	mdp_top u_dut (.*);
	mdp_host_model u_host (.*);
	task chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task sample(input logic [7:0] h, input logic [7:0] v);
		@(posedge clk);
		raw_valid <= 1'h1;
		raw_horizontal_delta <= h;
		raw_vertical_delta <= v;
		@(posedge clk);
		raw_valid <= 1'h0;
		#1;
		chk({7'h00, rpt_valid}, 8'h01);
	endtask : sample
	task print_verdict;
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : print_verdict
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	initial begin
		repeat (2000) @(posedge clk);
		bad_count++;
		print_verdict;
	end
	initial begin
		rst = 1'h1;
		raw_valid = 1'h0;
		raw_horizontal_delta = 8'h00;
		raw_vertical_delta = 8'h00;
		shutter = 16'h0400;
		orient_pin = 1'h1;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 10; i++) begin
			u_host.wr(QUANT_ADDR, tbl[i][0]);
			u_host.wr(SLOPE_ADDR, tbl[i][1]);
			u_host.wr(ORIENT_ADDR, tbl[i][2]);
			sample(tbl[i][3], tbl[i][4]);
			chk(horizontal_delta, tbl[i][5]);
			chk(vertical_delta, tbl[i][6]);
		end
		for (int i = 0; i < 4; i++) begin
			u_host.set_fpd(i[1], 16'h0400);
			@(posedge clk);
			shutter <= i[0] ? 16'h0420 : 16'h0400;
			repeat (2) @(posedge clk);
			#1;
			chk({7'h00, finger_presence_detect}, {7'h00, i[1] ^ i[0]});
		end
		@(posedge clk);
		orient_pin <= 1'h0;
		repeat (3) @(posedge clk);
		u_host.rd(ORIENT_ADDR, d);
		chk(d, 8'hA0);
		orient_pin <= 1'h1;
		rst <= 1'h1;
		repeat (6) @(posedge clk);
		rst <= 1'h0;
		for (int i = 0; i < 5; i++) begin
			u_host.rd(QUANT_ADDR + 8'(i), d);
			chk(d, rst_exp[i]);
		end
		u_host.wr(SLOPE_ADDR, 8'hFF);
		u_host.rd(SLOPE_ADDR, d);
		chk(d, 8'h07);
		print_verdict;
	end
endmodule : mdp_top_tb
